// ==== shared/qrc_pkg.sv ====
// Constants, state codes and helpers of the quad read command logic.
// Assumes one 24-bit byte address space and one link clock sampled by mclk.
package qrc_pkg;

    // ==========================================================
    // Command codes
    localparam logic [7:0] OP_QUAD_OUTPUT_READ = 8'h6B;
    localparam logic [7:0] OP_QUAD_IO_READ     = 8'hEB;
    localparam logic [7:0] OP_WRAP_SETUP       = 8'h77;
    localparam logic [7:0] OP_MODE_RESET       = 8'hFF;

    // ==========================================================
    // Phase lengths in link clocks
    localparam int         CNT_W            = 6;
    localparam logic [5:0] OPC_CLKS_SERIAL  = 6'h08;
    localparam logic [5:0] OPC_CLKS_QUAD    = 6'h02;
    localparam logic [5:0] ADDR_CLKS_SERIAL = 6'h18;
    localparam logic [5:0] ADDR_CLKS_QUAD   = 6'h06;
    localparam logic [5:0] QOR_DUMMY_CLKS   = 6'h08;
    localparam logic [5:0] MODE_CLKS        = 6'h02;
    localparam logic [5:0] SPI_DUMMY_DC0    = 6'h04;
    localparam logic [5:0] SPI_DUMMY_DC1    = 6'h06;
    localparam logic [5:0] WRAP_SETUP_CLKS  = 6'h20;
    localparam logic [5:0] QPI_DUMMY_P00    = 6'h0A;
    localparam logic [5:0] QPI_DUMMY_P01    = 6'h04;
    localparam logic [5:0] QPI_DUMMY_P10    = 6'h06;
    localparam logic [5:0] QPI_DUMMY_P11    = 6'h08;

    // ==========================================================
    // Mode byte and wrap settings
    localparam logic [1:0] CONT_KEY        = 2'b10;
    localparam logic [2:0] WRAP_CFG_RESET  = 3'h1;
    localparam int         ADDR_W          = 24;
    localparam int         FIFO_DEPTH_DEF  = 16;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_OPCODE  = 3'h1,
        ST_ADDR    = 3'h3,
        ST_MODE    = 3'h2,
        ST_DUMMY   = 3'h6,
        ST_DATA    = 3'h7,
        ST_WRAPCFG = 3'h5,
        ST_IGNORE  = 3'h4
    } qrc_state_t;

    // ==========================================================
    // Helpers
    function automatic logic [5:0] qrc_qpi_dummy(input logic [1:0] p);
        logic [5:0] n;
        unique case (p)
            2'b00: n = QPI_DUMMY_P00;
            2'b01: n = QPI_DUMMY_P01;
            2'b10: n = QPI_DUMMY_P10;
            2'b11: n = QPI_DUMMY_P11;
        endcase
        return n;
    endfunction : qrc_qpi_dummy

    function automatic logic [23:0] qrc_wrap_next(input logic [23:0] a,
                                                  input logic        on,
                                                  input logic [1:0]  len);
        logic [23:0] mask;
        logic [23:0] inc;
        mask = (24'h00_0008 << len) - 24'h00_0001;
        inc  = a + 24'h00_0001;
        return on ? ((a & ~mask) | (inc & mask)) : inc;
    endfunction : qrc_wrap_next

endpackage : qrc_pkg

// ==== rtl/qrc_fifo.sv ====
// Synchronous FIFO between the array fetch and the nibble shifter.
// Assumes DEPTH is a power of two; flush empties it in one cycle.
`timescale 1ns/100ps
module qrc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    wr_ptr_nxt;
    logic [PW-1:0]    rd_ptr_r;
    logic [PW-1:0]    rd_ptr_nxt;
    logic [PW:0]      count_r;
    logic [PW:0]      count_nxt;
    logic             push;
    logic             pop;

    assign in_ready  = (count_r != (PW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = mem_r[rd_ptr_r];
    assign push      = in_valid & in_ready & ~flush;
    assign pop       = out_valid & out_ready & ~flush;

    // ==========================================================
    // Pointers
    always_comb begin
        wr_ptr_nxt = wr_ptr_r + PW'(push);
        rd_ptr_nxt = rd_ptr_r + PW'(pop);
        count_nxt  = count_r + (PW+1)'(push) - (PW+1)'(pop);
        if (flush) begin
            wr_ptr_nxt = '0;
            rd_ptr_nxt = '0;
            count_nxt  = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else if (clk_en) begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
        end
    end

    // Storage has no reset; empty words are never read
    always_ff @(posedge mclk) begin
        if (clk_en && push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

endmodule : qrc_fifo

// ==== rtl/qrc_quad_read.sv ====
// Quad output and quad I/O read command logic of a serial flash device.
// Assumes the link clock and chip select come from the host as pins and
// that the array answers a read strobe with data one mclk later.
//
// How it works
// RULE1: Host sets quad enable before quad reads.
// RULE2: Address sampled on rise, nibbles out on fall.
// RULE3: Address steps per byte, rolls to zero.
// RULE4: Quad output read: serial address, eight dummies.
// RULE5: Chip select high ends read, stops driving.
// RULE6: Quad reads ignored while write cycle busy; continuous-mode frames are accepted without checking write_busy.
// RULE7: Quad I/O read: quad address, mode, dummies.
// RULE8: Quad I/O read phases use four bits/clock.
// RULE9: Host drives lines during mode byte clocks.
// RULE10: Mode key one-zero skips next opcode.
// RULE11: Other mode key restores full opcode.
// RULE12: Mode reset command clears continuous mode.
// RULE13: Host avoids key one-zero unless continuous.
// RULE14: Serial mode dummies chosen by config bit.
// RULE15: Four-line mode dummies from parameter bits.
// RULE16: Parameter default gives ten dummy clocks.
// RULE17: Four-line mode counts mode clocks as dummies.
// RULE18: Continuous mode works in both command modes.
// RULE19: No wrap for quad I/O in four-line mode.
// RULE20: Wrap setup: opcode, 24 dummies, wrap byte.
// RULE21: Wrap sections of 8 to 64 bytes.
// RULE22: Wrap bit four low enables, length from six-five.
// RULE23: Host rewrites wrap bit four to leave wrap.
// RULE24: Wrapped read cycles within its section.
// RULE25: Mode and wrap settings persist across frames.
`timescale 1ns/100ps
module qrc_quad_read
    import qrc_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    input  wire logic              sclk_pin,
    input  wire logic              cs_n_pin,
    input  wire logic [3:0]        io_in,
    output logic      [3:0]        io_out,
    output logic      [3:0]        io_oe,
    input  wire logic              quad_enable_bit,
    input  wire logic              write_busy,
    input  wire logic              four_line_command_mode,
    input  wire logic              dummy_cycle_config_bit,
    input  wire logic [1:0]        read_param_dummy_bits,
    output logic                   mem_rd_en,
    output logic      [ADDR_W-1:0] mem_addr,
    input  wire logic [7:0]        mem_rdata,
    output logic                   cont_mode_active,
    output logic      [2:0]        wrap_config_bits,
    output logic                   cmd_active
);
    // ==========================================================
    // Pin synchronisers and edge finding
    logic [2:0]        sclk_sync_r;
    logic [2:0]        cs_sync_r;
    logic [3:0]        io_s1_r;
    logic [3:0]        io_s2_r;
    logic              sclk_rise;
    logic              sclk_fall;
    logic              cs_fall;
    logic              cs_rise;
    logic              sample;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sclk_sync_r <= 3'h0;
            cs_sync_r   <= 3'h7;
            io_s1_r     <= 4'h0;
            io_s2_r     <= 4'h0;
        end else if (clk_en) begin
            sclk_sync_r <= {sclk_sync_r[1:0], sclk_pin};
            cs_sync_r   <= {cs_sync_r[1:0], cs_n_pin};
            io_s1_r     <= io_in;
            io_s2_r     <= io_s1_r;
        end
    end

    assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2];
    assign sclk_fall = ~sclk_sync_r[1] & sclk_sync_r[2];
    assign cs_fall   = ~cs_sync_r[1] & cs_sync_r[2];
    assign cs_rise   = cs_sync_r[1] & ~cs_sync_r[2];
    assign sample    = sclk_rise & ~cs_sync_r[1];

    // ==========================================================
    // Command state
    qrc_state_t        state_r;
    qrc_state_t        state_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  cnt_nxt;
    logic [7:0]        op_r;
    logic [7:0]        op_nxt;
    logic [23:0]       addr_r;
    logic [23:0]       addr_nxt;
    logic [7:0]        mode_r;
    logic [7:0]        mode_nxt;
    logic              quad_r;
    logic              quad_nxt;
    logic              is_qio_r;
    logic              is_qio_nxt;
    logic              cont_mode_r;
    logic              cont_mode_nxt;
    logic [2:0]        wrap_cfg_r;
    logic [2:0]        wrap_cfg_nxt;
    logic              nib_r;
    logic              nib_nxt;
    logic [7:0]        out_byte_r;
    logic [7:0]        out_byte_nxt;
    logic [3:0]        io_out_r;
    logic [3:0]        io_out_nxt;
    logic              oe_r;
    logic              oe_nxt;
    logic              fetch_on_r;
    logic              fetch_on_nxt;
    logic [23:0]       fetch_addr_r;
    logic [23:0]       fetch_addr_nxt;
    logic              rd_pend_r;
    logic              rd_pend_nxt;
    logic              wrap_act_r;
    logic              wrap_act_nxt;
    logic              last;
    logic [7:0]        op_sh;
    logic [23:0]       addr_sh;
    logic [7:0]        mode_sh;
    logic              op_last;
    logic              mode_last;
    logic              wrap_last;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic              fifo_pop;
    logic [7:0]        fifo_out_data;

    assign last      = (cnt_r == 6'h01);
    // RULE8 four bits per clock
    assign op_sh     = quad_r ? {op_r[3:0], io_s2_r} : {op_r[6:0], io_s2_r[0]};
    assign addr_sh   = quad_r ? {addr_r[19:0], io_s2_r} : {addr_r[22:0], io_s2_r[0]};
    assign mode_sh   = {mode_r[3:0], io_s2_r};
    assign op_last   = (state_r == ST_OPCODE) & sample & last;
    assign mode_last = (state_r == ST_MODE) & sample & last;
    assign wrap_last = (state_r == ST_WRAPCFG) & sample & last;
    assign fifo_pop  = (state_r == ST_DATA) & sclk_fall & ~cs_sync_r[1] & ~nib_r;
    // Fetch stalls on a full buffer; one read in flight at most
    assign mem_rd_en = fetch_on_r & fifo_in_ready & ~rd_pend_r;

    always_comb begin
        state_nxt      = state_r;
        cnt_nxt        = cnt_r;
        op_nxt         = op_r;
        addr_nxt       = addr_r;
        mode_nxt       = mode_r;
        quad_nxt       = quad_r;
        is_qio_nxt     = is_qio_r;
        cont_mode_nxt  = cont_mode_r;
        wrap_cfg_nxt   = wrap_cfg_r;
        nib_nxt        = nib_r;
        out_byte_nxt   = out_byte_r;
        io_out_nxt     = io_out_r;
        fetch_on_nxt   = fetch_on_r;
        fetch_addr_nxt = fetch_addr_r;
        rd_pend_nxt    = 1'b0;
        wrap_act_nxt   = wrap_act_r;
        // RULE3 RULE24 step address, wrap
        if (mem_rd_en) begin
            fetch_addr_nxt = qrc_wrap_next(fetch_addr_r, wrap_act_r, wrap_cfg_r[2:1]);
            rd_pend_nxt    = 1'b1;
        end
        unique case (state_r)
            ST_IDLE: begin
                if (cs_fall) begin
                    // RULE10 RULE18 opcode skipped
                    if (cont_mode_r) begin
                        state_nxt  = ST_ADDR;
                        quad_nxt   = 1'b1;
                        is_qio_nxt = 1'b1;
                        cnt_nxt    = ADDR_CLKS_QUAD;
                    end else begin
                        state_nxt  = ST_OPCODE;
                        quad_nxt   = four_line_command_mode;
                        cnt_nxt    = four_line_command_mode ? OPC_CLKS_QUAD : OPC_CLKS_SERIAL;
                    end
                end
            end
            ST_OPCODE: begin
                if (sample) begin
                    op_nxt  = op_sh;
                    cnt_nxt = cnt_r - 6'h01;
                    if (last) begin
                        state_nxt = ST_IGNORE;
                        // RULE6 RULE4 quad output accept
                        if (op_sh == OP_QUAD_OUTPUT_READ && !write_busy && quad_enable_bit
                            && !four_line_command_mode) begin
                            state_nxt  = ST_ADDR;
                            quad_nxt   = 1'b0;
                            is_qio_nxt = 1'b0;
                            cnt_nxt    = ADDR_CLKS_SERIAL;
                        end
                        // RULE6 RULE7 quad I/O accept
                        if (op_sh == OP_QUAD_IO_READ && !write_busy
                            && (quad_enable_bit || four_line_command_mode)) begin
                            state_nxt  = ST_ADDR;
                            quad_nxt   = 1'b1;
                            is_qio_nxt = 1'b1;
                            cnt_nxt    = ADDR_CLKS_QUAD;
                        end
                        // RULE20 wrap setup entry
                        if (op_sh == OP_WRAP_SETUP && !four_line_command_mode) begin
                            state_nxt = ST_WRAPCFG;
                            quad_nxt  = 1'b0;
                            cnt_nxt   = WRAP_SETUP_CLKS;
                        end
                        // RULE12 mode reset
                        if (op_sh == OP_MODE_RESET) begin
                            cont_mode_nxt = 1'b0;
                        end
                    end
                end
            end
            ST_ADDR: begin
                if (sample) begin
                    addr_nxt = addr_sh;
                    cnt_nxt  = cnt_r - 6'h01;
                    if (last) begin
                        fetch_on_nxt   = 1'b1;
                        fetch_addr_nxt = addr_sh;
                        // RULE19 RULE21 RULE22 wrap select
                        wrap_act_nxt   = is_qio_r & ~four_line_command_mode & ~wrap_cfg_r[0];
                        state_nxt      = is_qio_r ? ST_MODE : ST_DUMMY;
                        cnt_nxt        = is_qio_r ? MODE_CLKS : QOR_DUMMY_CLKS;
                    end
                end
            end
            ST_MODE: begin
                if (sample) begin
                    mode_nxt = mode_sh;
                    cnt_nxt  = cnt_r - 6'h01;
                    if (last) begin
                        // RULE10 RULE11 mode key
                        cont_mode_nxt = (mode_sh[5:4] == CONT_KEY);
                        state_nxt     = ST_DUMMY;
                        // RULE15 RULE16 RULE17 RULE14 dummy count
                        if (four_line_command_mode) begin
                            cnt_nxt = qrc_qpi_dummy(read_param_dummy_bits) - MODE_CLKS;
                        end else begin
                            cnt_nxt = dummy_cycle_config_bit ? SPI_DUMMY_DC1 : SPI_DUMMY_DC0;
                        end
                    end
                end
            end
            ST_DUMMY: begin
                if (sample) begin
                    cnt_nxt = cnt_r - 6'h01;
                    if (last) begin
                        state_nxt = ST_DATA;
                        nib_nxt   = 1'b0;
                    end
                end
            end
            ST_DATA: begin
                // RULE2 nibbles on falling edge
                if (sclk_fall && !cs_sync_r[1]) begin
                    if (!nib_r) begin
                        out_byte_nxt = fifo_out_valid ? fifo_out_data : 8'h00;
                        io_out_nxt   = out_byte_nxt[7:4];
                        nib_nxt      = 1'b1;
                    end else begin
                        io_out_nxt = out_byte_r[3:0];
                        nib_nxt    = 1'b0;
                    end
                end
            end
            ST_WRAPCFG: begin
                if (sample) begin
                    addr_nxt = addr_sh;
                    cnt_nxt  = cnt_r - 6'h01;
                    // RULE20 RULE25 latch wrap bits
                    if (last) begin
                        wrap_cfg_nxt = addr_sh[6:4];
                        state_nxt    = ST_IGNORE;
                    end
                end
            end
            ST_IGNORE: begin
                state_nxt = ST_IGNORE;
            end
        endcase
        // RULE5 frame end stops all
        if (cs_rise) begin
            state_nxt    = ST_IDLE;
            fetch_on_nxt = 1'b0;
            rd_pend_nxt  = 1'b0;
            io_out_nxt   = 4'h0;
        end
        oe_nxt = (state_nxt == ST_DATA);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r      <= ST_IDLE;
            cnt_r        <= '0;
            op_r         <= 8'h00;
            addr_r       <= 24'h00_0000;
            mode_r       <= 8'h00;
            quad_r       <= 1'b0;
            is_qio_r     <= 1'b0;
            cont_mode_r  <= 1'b0;
            wrap_cfg_r   <= WRAP_CFG_RESET;
            nib_r        <= 1'b0;
            out_byte_r   <= 8'h00;
            io_out_r     <= 4'h0;
            oe_r         <= 1'b0;
            fetch_on_r   <= 1'b0;
            fetch_addr_r <= 24'h00_0000;
            rd_pend_r    <= 1'b0;
            wrap_act_r   <= 1'b0;
        end else if (clk_en) begin
            state_r      <= state_nxt;
            cnt_r        <= cnt_nxt;
            op_r         <= op_nxt;
            addr_r       <= addr_nxt;
            mode_r       <= mode_nxt;
            quad_r       <= quad_nxt;
            is_qio_r     <= is_qio_nxt;
            cont_mode_r  <= cont_mode_nxt;
            wrap_cfg_r   <= wrap_cfg_nxt;
            nib_r        <= nib_nxt;
            out_byte_r   <= out_byte_nxt;
            io_out_r     <= io_out_nxt;
            oe_r         <= oe_nxt;
            fetch_on_r   <= fetch_on_nxt;
            fetch_addr_r <= fetch_addr_nxt;
            rd_pend_r    <= rd_pend_nxt;
            wrap_act_r   <= wrap_act_nxt;
        end
    end

    // ==========================================================
    // Prefetch buffer
    qrc_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .flush     (cs_rise),
        .in_valid  (rd_pend_r),
        .in_ready  (fifo_in_ready),
        .in_data   (mem_rdata),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    assign io_out           = io_out_r;
    assign io_oe            = {4{oe_r}};
    assign mem_addr         = fetch_addr_r;
    assign cont_mode_active = cont_mode_r;
    assign wrap_config_bits = wrap_cfg_r;
    assign cmd_active       = (state_r != ST_IDLE);

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst || !clk_en);

    sequence s_cs_rise;
        cs_rise;
    endsequence
    sequence s_quiet;
        (io_oe == 4'h0) && (state_r == ST_IDLE);
    endsequence

    AST_OE_IN_DATA: assert property (io_oe != 4'h0 |-> state_r == ST_DATA) // RULE2
        else $error("lines driven outside data phase");
    AST_CS_RISE_STOP: assert property (s_cs_rise |=> s_quiet) // RULE5
        else $error("drive kept after chip select rise");
    AST_BUSY_REJECT: assert property (op_last && write_busy && !cs_rise // RULE6
        && op_sh != OP_WRAP_SETUP |=> state_r == ST_IGNORE)
        else $error("read accepted while write busy");
    AST_CONT_SET: assert property (mode_last && mode_sh[5:4] == CONT_KEY |=> cont_mode_r) // RULE10
        else $error("continuous mode not entered");
    AST_CONT_CLEAR: assert property (mode_last && mode_sh[5:4] != CONT_KEY |=> // RULE11
        !cont_mode_r)
        else $error("continuous mode not left");
    AST_MODE_RESET: assert property (op_last && op_sh == OP_MODE_RESET |=> !cont_mode_r) // RULE12
        else $error("mode reset did not clear");
    AST_WRAP_LATCH: assert property (wrap_last |=> wrap_config_bits == addr_r[6:4]) // RULE20
        else $error("wrap bits not latched");
    AST_QPI_DUMMY: assert property (mode_last && four_line_command_mode && !cs_rise |=> // RULE15
        state_r == ST_DUMMY && cnt_r == qrc_qpi_dummy($past(read_param_dummy_bits)) - MODE_CLKS)
        else $error("wrong four-line dummy count");
    AST_ADDR_STEP: assert property (mem_rd_en && !cs_rise |=> // RULE3
        fetch_addr_r == qrc_wrap_next($past(fetch_addr_r), wrap_act_r, wrap_cfg_r[2:1]))
        else $error("fetch address step wrong");
    AST_CONT_SKIP: assert property (state_r == ST_IDLE && cs_fall && cont_mode_r |=> // RULE10
        state_r == ST_ADDR ##0 quad_r)
        else $error("opcode not skipped in continuous mode");

endmodule : qrc_quad_read

// ==== test/qrc_host_model.sv ====
// Host model: link clock, chip select and I/O lines of the flash host.
// Assumes mclk of 20 ns; one link clock spans eight mclk.
`timescale 1ns/100ps
module qrc_host_model (
    input  wire logic       mclk,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe,
    output logic            sclk_pin,
    output logic            cs_n_pin,
    output logic      [3:0] io_in
);
    // ========
    // Lines
    logic [3:0] h_dat  = 4'h0;
    logic       h_oe   = 1'b0;
    logic       saw_oe = 1'b0;
    logic [3:0] q;
    logic [7:0] rdat [0:15];
    // Released lines invert, so a stale value never passes
    assign io_in = (io_oe & io_out) | (~io_oe & (h_oe ? h_dat : ~h_dat));
    initial begin
        sclk_pin = 1'b0;
        cs_n_pin = 1'b1;
    end
    // ========
    // Link steps
    task automatic half;
        repeat (4) @(negedge mclk);
    endtask : half
    // Clock stands still outside ticks
    task automatic tick(input logic [3:0] n, input logic drv);
        if (drv) h_dat = n;
        h_oe = drv;
        half();
        sclk_pin = 1'b1;
        q = io_out;
        if (io_oe != 4'h0) saw_oe = 1'b1;
        half();
        sclk_pin = 1'b0;
    endtask : tick
    task automatic sel;
        cs_n_pin = 1'b0;
        half();
    endtask : sel
    task automatic desel;
        half();
        cs_n_pin = 1'b1;
        h_oe = 1'b0;
        repeat (4) half();
    endtask : desel
    task automatic bits(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) tick({3'h0, v[i]}, 1'b1);
    endtask : bits
    task automatic nibs(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) tick(v[4*i +: 4], 1'b1);
    endtask : nibs
    task automatic idle(input int n);
        repeat (n) tick(4'h0, 1'b0);
    endtask : idle
    task automatic rd(input int n);
        for (int k = 0; k < n; k++) begin
            tick(4'h0, 1'b0);
            rdat[k][7:4] = q;
            tick(4'h0, 1'b0);
            rdat[k][3:0] = q;
        end
    endtask : rd
endmodule : qrc_host_model

// ==== test/tb_top.sv ====
// Bench of the quad read command logic with a host model and array model.
// Assumes the array answers a strobe one mclk later.
`timescale 1ns/100ps
module tb_top import qrc_pkg::*; ;
    logic mclk = 1'b0, sys_rst = 1'b1, wb = 1'b0, flm = 1'b0, dcb = 1'b0;
    logic [1:0] rpb = 2'h0, ln;
    logic [7:0] mem_rdata = 8'h00;
    logic [3:0] io_in, io_out, io_oe;
    logic sclk_pin, cs_n_pin, mem_rd_en, cont_mode_active;
    logic [23:0] mem_addr, a;
    logic [2:0] wrap_config_bits;
    int fail_count = 0, n_compared = 0, seed = 32'h6736, tbl [4] = '{10, 4, 6, 8};
    always #10 mclk = ~mclk;
    function automatic logic [7:0] byte_at(input logic [23:0] x);
        return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h5A;
    endfunction : byte_at
    function automatic logic [23:0] nxt(input logic [23:0] x, input logic on,
                                        input logic [1:0] len);
        logic [23:0] m;
        m = 24'h00_0008 << len;
        return x + 24'h00_0001 - ((on && (x + 24'h00_0001) % m == 0) ? m : 24'h00_0000);
    endfunction : nxt
    always @(posedge mclk) if (mem_rd_en) mem_rdata <= byte_at(mem_addr);
    qrc_quad_read i_dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .sclk_pin(sclk_pin),
        .cs_n_pin(cs_n_pin), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .quad_enable_bit(1'b1), .write_busy(wb), .four_line_command_mode(flm),
        .dummy_cycle_config_bit(dcb), .read_param_dummy_bits(rpb), .mem_rd_en(mem_rd_en),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .cont_mode_active(cont_mode_active),
        .wrap_config_bits(wrap_config_bits), .cmd_active());
    qrc_host_model i_host (.mclk(mclk), .io_out(io_out), .io_oe(io_oe),
        .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .io_in(io_in));
    // ========
    // Tasks
    task automatic cmp(input logic [23:0] g, input logic [23:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task automatic chk(input logic [23:0] s, input logic on, input logic [1:0] len, input int n);
        for (int k = 0; k < n; k++) begin
            cmp({16'h0, i_host.rdat[k]}, {16'h0, byte_at(s)});
            s = nxt(s, on, len);
        end
    endtask : chk
    task automatic qio(input logic c, input logic [23:0] s, input logic [7:0] m, input int d,
                       input int n);
        i_host.sel();
        if (!c && flm) i_host.nibs(OP_QUAD_IO_READ, 2);
        else if (!c) i_host.bits(OP_QUAD_IO_READ, 8);
        i_host.nibs(s, 6);
        i_host.nibs(m, 2);
        i_host.idle(d);
        i_host.rd(n);
        i_host.desel();
    endtask : qio
    task automatic wrap(input logic [2:0] w);
        i_host.sel();
        i_host.bits(OP_WRAP_SETUP, 8);
        i_host.bits({24'h00_0000, 1'b0, w, 4'h0}, 32);
        i_host.desel();
    endtask : wrap
    task automatic qor(input logic [23:0] s, input int n);
        i_host.sel();
        i_host.bits(OP_QUAD_OUTPUT_READ, 8);
        i_host.bits(s, 24);
        i_host.idle(8);
        i_host.rd(n);
        i_host.desel();
    endtask : qor
    task automatic close_out;
        $display("compared=%0d failed=%0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    // ========
    // Scenarios
    initial begin
        repeat (6) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (2) @(negedge mclk);
        cmp({21'h0, wrap_config_bits}, 24'h1);
        a = $random(seed);
        qio(1'b0, a, 8'h20, 4, 4);
        chk(a, 1'b0, 2'h0, 4);
        cmp({23'h0, cont_mode_active}, 24'h1);
        cmp({20'h0, io_oe}, 24'h0);
        a = $random(seed);
        qio(1'b1, a, 8'hF0, 4, 2);
        chk(a, 1'b0, 2'h0, 2);
        cmp({23'h0, cont_mode_active}, 24'h0);
        dcb = 1'b1;
        qio(1'b0, a, 8'h20, 6, 2);
        chk(a, 1'b0, 2'h0, 2);
        dcb = 1'b0;
        repeat (2) begin
            i_host.sel();
            i_host.nibs(32'hFFFF_FFFF, 8);
            i_host.desel();
            cmp({23'h0, cont_mode_active}, 24'h0);
        end
        ln = $random(seed);
        wrap({ln, 1'b0});
        cmp({21'h0, wrap_config_bits}, {21'h0, ln, 1'b0});
        a = $random(seed);
        qio(1'b0, a, 8'h00, 4, 12);
        chk(a, 1'b1, ln, 12);
        wb = 1'b1;
        i_host.saw_oe = 1'b0;
        qor(a, 2);
        cmp({23'h0, i_host.saw_oe}, 24'h0);
        wb = 1'b0;
        qor(24'hFF_FFFF, 3);
        chk(24'hFF_FFFF, 1'b0, 2'h0, 3);
        flm = 1'b1;
        for (int p = 0; p < 4; p++) begin
            rpb = 2'(p);
            qio(1'b0, a, 8'h00, tbl[p] - 2, 12);
            chk(a, 1'b0, 2'h0, 12);
        end
        flm = 1'b0;
        wrap({ln, 1'b1});
        cmp({21'h0, wrap_config_bits}, {21'h0, ln, 1'b1});
        close_out();
    end
    // Hang guard well past the expected run
    initial begin
        #1_000_000;
        fail_count++;
        close_out();
    end
endmodule : tb_top
